// File: hdl/idj_defs.svh
// Constants of the increment, decrement, invert, interrupt enable and jump unit.
`ifndef IDJ_DEFS_SVH
`define IDJ_DEFS_SVH

// ----------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------
`define IDJ_C_BIT      0
`define IDJ_Z_BIT      1
`define IDJ_N_BIT      2
`define IDJ_GIE_BIT    3
`define IDJ_PROCESSOR_OFF_BIT_BIT 4
`define IDJ_OSCILLATOR_OFF_BIT_BIT 5
`define IDJ_V_BIT      8

// ----------------------------------------------------------------------
// Masks and operand constants
// ----------------------------------------------------------------------
`define IDJ_GIE_MASK   16'h0008
`define IDJ_SIGN_W     16'h8000
`define IDJ_SIGN_B     16'h0080
`define IDJ_ONES_W     16'hFFFF
`define IDJ_ONES_B     16'h00FF
`define IDJ_ONE        16'h0001
`define IDJ_TWO        16'h0002
`define IDJ_JOFS_W     10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IDJ_RST_WORD   16'h0000

`endif

// File: hdl/idj_exec.sv
// Execution unit for increment, decrement, invert, interrupt enable and carry jump.
`include "idj_defs.svh"
`default_nettype none
module idj_exec (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             clock_en,
    input  wire idj_pkg::idj_req_t req,
    output var  idj_pkg::idj_rsp_t rsp,
    output var  logic             irq_block
);

    // ------------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------------

    logic is_dec1;
    logic is_dec2;
    logic is_inc1;
    logic is_inc2;
    logic is_inv;
    logic is_interrupt_disable_op;
    logic is_interrupt_enable_op;
    logic is_arith;
    logic take;

    // The carry jump arrives as its own flag; when it shares a cycle with an op code, it blocks that op code's writes.
    assign is_dec1  = req.op == idj_pkg::IDJ_OP_DEC1;
    assign is_dec2  = req.op == idj_pkg::IDJ_OP_DEC2;
    assign is_inc1  = req.op == idj_pkg::IDJ_OP_INC1;
    assign is_inc2  = req.op == idj_pkg::IDJ_OP_INC2;
    assign is_inv   = req.op == idj_pkg::IDJ_OP_INV;
    assign is_interrupt_disable_op  = req.op == idj_pkg::IDJ_OP_INTERRUPT_DISABLE_OP;
    assign is_interrupt_enable_op  = req.op == idj_pkg::IDJ_OP_INTERRUPT_ENABLE_OP;
    assign is_arith = is_dec1 | is_dec2 | is_inc1 | is_inc2 | is_inv;
    assign take     = clock_en & req.valid;

    // ------------------------------------------------------------------
    // Operand width handling
    // ------------------------------------------------------------------

    logic [15:0] ones;
    logic [15:0] sign;
    logic [15:0] val;

    // Byte forms work on the low byte only, with bit 7 as the sign.
    assign ones = req.byte_mode ? `IDJ_ONES_B : `IDJ_ONES_W;
    assign sign = req.byte_mode ? `IDJ_SIGN_B : `IDJ_SIGN_W;
    assign val  = req.dst & ones;

    // ------------------------------------------------------------------
    // Result
    // ------------------------------------------------------------------

    logic [15:0] raw;
    logic [15:0] result;
    logic        res_neg;

    assign raw = is_dec1 ? val - `IDJ_ONE :
                 is_dec2 ? val - `IDJ_TWO :
                 is_inc1 ? val + `IDJ_ONE :
                 is_inc2 ? val + `IDJ_TWO :
                 ~val;
    // Masking drops the borrow or carry above the width, and in byte forms empties the upper byte.
    assign result  = raw & ones;
    assign res_neg = |(result & sign);

    // ------------------------------------------------------------------
    // Flags, taken from the operand value rather than from an adder carry
    // ------------------------------------------------------------------

    logic [15:0] max_pos;
    logic        was_ones;
    logic        flag_z;
    logic        flag_c;
    logic        flag_v;

    assign max_pos  = sign - `IDJ_ONE;
    assign was_ones = val == ones;

    assign flag_z = is_dec1 ? val == `IDJ_ONE :
                    is_dec2 ? val == `IDJ_TWO :
                    is_inc1 ? was_ones :
                    is_inc2 ? val == ones - `IDJ_ONE :
                    was_ones;

    assign flag_c = is_dec1 ? val != `IDJ_RST_WORD :
                    is_dec2 ? val > `IDJ_ONE :
                    is_inc1 ? was_ones :
                    is_inc2 ? val >= ones - `IDJ_ONE :
                    !was_ones;

    assign flag_v = is_dec1 ? val == sign :
                    is_dec2 ? (val == sign) |
                              (val == sign + `IDJ_ONE) :
                    is_inc1 ? val == max_pos :
                    is_inc2 ? (val == max_pos) |
                              (val == max_pos - `IDJ_ONE) :
                    |(val & sign);

    // ------------------------------------------------------------------
    // Status register update
    // ------------------------------------------------------------------

    logic [15:0] sr_arith;
    logic [15:0] sr_next;

    // Only the four arithmetic flags are replaced; mode bits pass through as read.
    always_comb begin
        sr_arith                 = req.sr;
        sr_arith[`IDJ_C_BIT]     = flag_c;
        sr_arith[`IDJ_Z_BIT]     = flag_z;
        sr_arith[`IDJ_N_BIT]     = res_neg;
        sr_arith[`IDJ_V_BIT]     = flag_v;
    end

    assign sr_next = is_interrupt_disable_op ? req.sr & ~`IDJ_GIE_MASK :
                     is_interrupt_enable_op ? req.sr | `IDJ_GIE_MASK :
                     sr_arith;

    // ------------------------------------------------------------------
    // Carry jump
    // ------------------------------------------------------------------

    logic        jump_go;
    logic [15:0] jump_step;
    logic [15:0] jump_pc;

    // The incoming PC already points at the next instruction.
    assign jump_go   = req.jump_carry & req.sr[`IDJ_C_BIT];
    assign jump_step = {{5{req.offset[`IDJ_JOFS_W-1]}}, req.offset, 1'b0};
    assign jump_pc   = req.pc + jump_step;

    // ------------------------------------------------------------------
    // Write-back word
    // ------------------------------------------------------------------

    idj_pkg::idj_rsp_t next_rsp;
    logic              next_block;

    assign next_rsp.valid   = req.valid;
    assign next_rsp.dst_we  = req.valid & is_arith & !req.jump_carry;
    assign next_rsp.byte_we = req.byte_mode & !req.dst_is_reg;
    assign next_rsp.result  = result;
    assign next_rsp.sr_we   = req.valid & !req.jump_carry &
                              (is_arith | is_interrupt_disable_op | is_interrupt_enable_op);
    assign next_rsp.sr      = sr_next;
    assign next_rsp.pc_we   = req.valid & jump_go;
    assign next_rsp.pc      = jump_pc;

    // Interrupt service is held off for exactly one more instruction after enable.
    assign next_block = is_interrupt_enable_op & !req.jump_carry;

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------

    // Outputs come straight from flops so the write-back path sees a clean edge.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rsp <= '0;
        end else if (clock_en) begin
            rsp <= next_rsp;
        end
    end

    // The hold-off clears only when the following instruction retires.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_block <= 1'b0;
        end else if (take) begin
            irq_block <= next_block;
        end
    end

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------

    idj_pkg::idj_req_t last;
    logic [15:0]       l_ones;
    logic [15:0]       l_sign;
    logic [15:0]       l_val;
    logic [15:0]       l_ofs;
    logic              l_arith;

    // A copy of the request sampled at the last enabled edge, valid or not, read only by the checks below.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            last <= '0;
        end else if (clock_en) begin
            last <= req;
        end
    end

    assign l_ones  = last.byte_mode ? `IDJ_ONES_B : `IDJ_ONES_W;
    assign l_sign  = last.byte_mode ? `IDJ_SIGN_B : `IDJ_SIGN_W;
    assign l_val   = last.dst & l_ones;
    assign l_ofs   = {{5{last.offset[`IDJ_JOFS_W-1]}}, last.offset, 1'b0};
    assign l_arith = rsp.valid & !last.jump_carry & (last.op != idj_pkg::IDJ_OP_NONE) &
                     (last.op != idj_pkg::IDJ_OP_INTERRUPT_DISABLE_OP) & (last.op != idj_pkg::IDJ_OP_INTERRUPT_ENABLE_OP);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    accept_pulse_a: assert property (take |=> rsp.valid)
        else $error("accepted request gave no write-back");

    dec_one_a: assert property (
        l_arith && last.op == idj_pkg::IDJ_OP_DEC1 |->
        rsp.result == ((l_val - `IDJ_ONE) & l_ones) &&
        rsp.sr[`IDJ_Z_BIT] == (l_val == `IDJ_ONE) &&
        rsp.sr[`IDJ_C_BIT] == (l_val != `IDJ_RST_WORD))
        else $error("single decrement result or flags wrong");

    dec_one_ovf_a: assert property (
        l_arith && last.op == idj_pkg::IDJ_OP_DEC1 |->
        rsp.sr[`IDJ_V_BIT] == (l_val == l_sign))
        else $error("single decrement overflow wrong");

    neg_flag_a: assert property (
        l_arith |-> rsp.sr[`IDJ_N_BIT] == |(rsp.result & l_sign))
        else $error("negative flag does not match result sign");

    dec_two_a: assert property (
        l_arith && last.op == idj_pkg::IDJ_OP_DEC2 |->
        rsp.result == ((l_val - `IDJ_TWO) & l_ones) &&
        rsp.sr[`IDJ_Z_BIT] == (l_val == `IDJ_TWO) &&
        rsp.sr[`IDJ_C_BIT] == (l_val > `IDJ_ONE) &&
        rsp.sr[`IDJ_V_BIT] == ((l_val == l_sign) || (l_val == l_sign + `IDJ_ONE)))
        else $error("double decrement result or flags wrong");

    mode_bits_a: assert property (
        l_arith |-> rsp.sr[`IDJ_GIE_BIT] == last.sr[`IDJ_GIE_BIT] &&
        rsp.sr[`IDJ_PROCESSOR_OFF_BIT_BIT] == last.sr[`IDJ_PROCESSOR_OFF_BIT_BIT] &&
        rsp.sr[`IDJ_OSCILLATOR_OFF_BIT_BIT] == last.sr[`IDJ_OSCILLATOR_OFF_BIT_BIT])
        else $error("arithmetic operation touched a mode bit");

    int_disable_a: assert property (
        take && is_interrupt_disable_op && !req.jump_carry |=>
        rsp.sr_we && rsp.sr == (last.sr & ~`IDJ_GIE_MASK))
        else $error("interrupt disable changed more than the enable bit");

    int_enable_a: assert property (
        take && is_interrupt_enable_op && !req.jump_carry |=>
        rsp.sr_we && rsp.sr == (last.sr | `IDJ_GIE_MASK) && irq_block)
        else $error("interrupt enable wrong");

    hold_release_a: assert property (
        irq_block && take && !next_block |=> !irq_block)
        else $error("interrupt hold-off not released after next instruction");

    inc_one_a: assert property (
        l_arith && last.op == idj_pkg::IDJ_OP_INC1 |->
        rsp.result == ((l_val + `IDJ_ONE) & l_ones) &&
        rsp.sr[`IDJ_Z_BIT] == (l_val == l_ones) &&
        rsp.sr[`IDJ_C_BIT] == (l_val == l_ones) &&
        rsp.sr[`IDJ_V_BIT] == (l_val == l_sign - `IDJ_ONE))
        else $error("single increment flags wrong");

    inc_two_a: assert property (
        l_arith && last.op == idj_pkg::IDJ_OP_INC2 |->
        rsp.result == ((l_val + `IDJ_TWO) & l_ones) &&
        rsp.sr[`IDJ_Z_BIT] == (l_val == l_ones - `IDJ_ONE) &&
        rsp.sr[`IDJ_C_BIT] == (l_val >= l_ones - `IDJ_ONE) &&
        rsp.sr[`IDJ_V_BIT] == ((l_val == l_sign - `IDJ_ONE) || (l_val == l_sign - `IDJ_TWO)))
        else $error("double increment result or flags wrong");

    invert_a: assert property (
        l_arith && last.op == idj_pkg::IDJ_OP_INV |->
        rsp.result == (~l_val & l_ones) &&
        rsp.sr[`IDJ_Z_BIT] == (l_val == l_ones) &&
        rsp.sr[`IDJ_C_BIT] == !rsp.sr[`IDJ_Z_BIT] &&
        rsp.sr[`IDJ_V_BIT] == |(l_val & l_sign))
        else $error("invert result or flags wrong");

    carry_jump_a: assert property (
        rsp.valid && last.jump_carry |->
        rsp.pc_we == last.sr[`IDJ_C_BIT] && rsp.pc == last.pc + l_ofs)
        else $error("carry jump target or decision wrong");

    byte_upper_a: assert property (
        l_arith && last.byte_mode |-> rsp.result[15:8] == 8'h00)
        else $error("byte result has a non-zero upper byte");

    // Strobes are checked apart from data; a stray strobe corrupts state silently.
    arith_strobe_a: assert property (
        l_arith |-> rsp.dst_we && rsp.sr_we && !rsp.pc_we)
        else $error("arithmetic operation has wrong write strobes");

    byte_strobe_a: assert property (
        l_arith |-> rsp.byte_we == (last.byte_mode && !last.dst_is_reg))
        else $error("byte write strobe wrong");

    jump_quiet_a: assert property (
        rsp.valid && last.jump_carry |-> !rsp.sr_we && !rsp.dst_we)
        else $error("carry jump wrote status or destination");

    none_quiet_a: assert property (
        rsp.valid && !last.jump_carry && last.op == idj_pkg::IDJ_OP_NONE |->
        !rsp.dst_we && !rsp.sr_we && !rsp.pc_we)
        else $error("empty operation wrote back");

    idle_quiet_a: assert property (
        !rsp.valid |-> !rsp.dst_we && !rsp.sr_we && !rsp.pc_we)
        else $error("write strobe without valid");

    // A stalled enable must freeze the whole answer, not only the valid bit.
    stall_hold_a: assert property (
        !clock_en |=> $stable(rsp) && $stable(irq_block))
        else $error("state moved while clock enable was low");

    block_set_a: assert property (
        $rose(irq_block) |-> last.op == idj_pkg::IDJ_OP_INTERRUPT_ENABLE_OP && !last.jump_carry)
        else $error("interrupt hold-off set by something other than enable");

endmodule
`default_nettype wire

// File: hdl/idj_pkg.sv
// Types shared by the increment, decrement, invert and jump unit.
`default_nettype none
package idj_pkg;

    // Operation codes as handed over by the instruction decoder.
    typedef enum logic [2:0] {
        IDJ_OP_NONE = 3'h0,
        IDJ_OP_DEC1 = 3'h1,
        IDJ_OP_DEC2 = 3'h2,
        IDJ_OP_INC1 = 3'h3,
        IDJ_OP_INC2 = 3'h4,
        IDJ_OP_INV  = 3'h5,
        IDJ_OP_INTERRUPT_DISABLE_OP = 3'h6,
        IDJ_OP_INTERRUPT_ENABLE_OP = 3'h7
    } idj_op_t;

    // One instruction with its fetched operands.
    typedef struct packed {
        logic        valid;
        idj_op_t     op;
        logic        jump_carry;
        logic        byte_mode;
        logic        dst_is_reg;
        logic [15:0] dst;
        logic [15:0] sr;
        logic [15:0] pc;
        logic [9:0]  offset;
    } idj_req_t;

    // Write-back towards register file, status register and program counter.
    typedef struct packed {
        logic        valid;
        logic        dst_we;
        logic        byte_we;
        logic [15:0] result;
        logic        sr_we;
        logic [15:0] sr;
        logic        pc_we;
        logic [15:0] pc;
    } idj_rsp_t;

endpackage
`default_nettype wire

// File: verification/idj_wb_model.sv
// Write-back model standing for the register file and status register behind the unit.
`default_nettype none
module idj_wb_model (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire idj_pkg::idj_rsp_t rsp,
    output var  logic [15:0]       dst_q,
    output var  logic [15:0]       sr_q
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Write-back
    // ------------------------------------------------------------------
    // Strobes are honoured only with valid, as the real register file would.
    // A byte memory write keeps the upper byte, so a wrong byte_we shows up.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dst_q <= 16'h0000;
            sr_q  <= 16'h0000;
        end else if (rsp.valid) begin
            if (rsp.dst_we && rsp.byte_we) begin
                dst_q[7:0] <= rsp.result[7:0];
            end else if (rsp.dst_we) begin
                dst_q <= rsp.result;
            end
            if (rsp.sr_we) begin
                sr_q <= rsp.sr;
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/test_incdec_invert_gie_jump_ops.sv
// Self-checking testbench of the increment, decrement, invert, interrupt enable and jump unit.
`default_nettype none
module test_incdec_invert_gie_jump_ops;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clock = 1'b0;
    logic              reset_n;
    logic              clock_en;
    idj_pkg::idj_req_t req;
    idj_pkg::idj_rsp_t rsp;
    logic              irq_block;
    logic [15:0]       wb_dst;
    logic [15:0]       wb_sr;
    int                errors = 0;
    int                check_count = 0;
    logic [15:0]       vals [16] = '{16'h0000, 16'h0001, 16'h0002, 16'h007E, 16'h007F,
        16'h0080, 16'h0081, 16'h00FE, 16'h00FF, 16'h7FFE, 16'h7FFF, 16'h8000, 16'h8001,
        16'hFFFE, 16'hFFFF, 16'h1234};

    idj_exec u_dut (.clock(clock), .reset_n(reset_n), .clock_en(clock_en), .req(req),
                    .rsp(rsp), .irq_block(irq_block));
    idj_wb_model u_wb (.clock(clock), .reset_n(reset_n), .rsp(rsp), .dst_q(wb_dst),
                       .sr_q(wb_sr));

    // 20 MHz clock.
    always #25 clock = ~clock;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Expected result and status; flags are taken from operand values, not from a subtraction.
    function automatic void calc(input logic [2:0] op, input logic b, input logic [15:0] d0,
                                 input logic [15:0] s, output logic [15:0] r,
                                 output logic [15:0] so);
        logic [15:0] m;
        logic [15:0] sg;
        logic [15:0] d;
        logic        z;
        logic        c;
        logic        v;
        m = b ? 16'h00FF : 16'hFFFF;
        sg = b ? 16'h0080 : 16'h8000;
        d = d0 & m;
        r = op == 3'h1 ? d - 16'h0001 : op == 3'h2 ? d - 16'h0002 :
            op == 3'h3 ? d + 16'h0001 : op == 3'h4 ? d + 16'h0002 : ~d;
        r = r & m;
        z = op == 3'h1 ? d == 16'h0001 : op == 3'h2 ? d == 16'h0002 :
            op == 3'h4 ? d == m - 16'h0001 : d == m;
        c = op == 3'h1 ? d != 16'h0000 : op == 3'h2 ? d > 16'h0001 : op == 3'h3 ? d == m :
            op == 3'h4 ? d >= m - 16'h0001 : d != m;
        v = op == 3'h1 ? d == sg : op == 3'h2 ? (d == sg || d == sg + 16'h0001) :
            op == 3'h3 ? d == sg - 16'h0001 :
            op == 3'h4 ? (d == sg - 16'h0001 || d == sg - 16'h0002) : (d & sg) != 16'h0000;
        so = {s[15:9], v, s[7:3], (r & sg) != 0, z, c};
        if (op == 3'h6) begin
            so = s & ~16'h0008;
        end
        if (op == 3'h7) begin
            so = s | 16'h0008;
        end
    endfunction

    // Present one request at a rising edge; it is taken at the following edge.
    task automatic send(input logic [2:0] op, input logic jc, input logic b, input logic rg,
                        input logic [15:0] d, input logic [15:0] s, input logic [9:0] off);
        @(posedge clock);
        req <= '{1'b1, idj_pkg::idj_op_t'(op), jc, b, rg, d, s, 16'h0100, off};
    endtask

    // Let the taking edge pass, drop valid and wait for the answer to settle.
    task automatic take();
        @(posedge clock);
        req.valid <= 1'b0;
        #1;
    endtask

    task automatic run_op(input logic [2:0] op, input logic b, input logic rg,
                          input logic [15:0] d, input logic [15:0] s);
        logic [15:0] er;
        logic [15:0] es;
        logic [15:0] prev;
        logic        ar;
        calc(op, b, d, s, er, es);
        ar = op < 3'h6;
        prev = wb_dst;
        send(op, 1'b0, b, rg, d, s, 10'h000);
        take();
        chk(rsp.valid, 1'b1, "valid");
        chk(rsp.sr, es, "sr");
        chk(rsp.sr_we, 1'b1, "sr_we");
        chk(rsp.dst_we, ar, "dst_we");
        if (ar) chk(rsp.result, er, "result");
        if (ar) chk(rsp.byte_we, b & !rg, "byte_we");
        chk(rsp.pc_we, 1'b0, "pc_we");
        @(posedge clock);
        #1;
        chk(wb_sr, es, "sr written");
        if (ar) chk(wb_dst, (b && !rg) ? {prev[15:8], er[7:0]} : er, "dst written");
    endtask

    task automatic run_jump(input logic c, input logic [9:0] off);
        send(3'h0, 1'b1, 1'b0, 1'b1, 16'h0000, {15'h0000, c}, off);
        take();
        chk(rsp.pc_we, c, "jump taken");
        if (c) chk(rsp.pc, 16'h0100 + {{5{off[9]}}, off, 1'b0}, "jump pc");
        chk(rsp.dst_we, 1'b0, "jump dst_we");
        chk(rsp.sr_we, 1'b0, "jump sr_we");
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        clock_en = 1'b1;
        req = '0;
        repeat (12) @(posedge clock);
        #1;
        chk(rsp.valid, 1'b0, "reset valid");
        chk(irq_block, 1'b0, "reset irq_block");
        @(posedge clock);
        reset_n <= 1'b1;
        // Every operation on boundary operands, both widths, register and memory targets.
        for (int k = 1; k < 8; k++) begin
            for (int i = 0; i < 32; i++) begin
                run_op(k[2:0], i[4], i[1], vals[i[3:0]], i[0] ? 16'h0138 : 16'h0007);
            end
        end
        run_jump(1'b1, 10'h3FF);
        run_jump(1'b1, 10'h200);
        run_jump(1'b1, 10'h1FF);
        run_jump(1'b0, 10'h010);
        // Enable then disable back to back; the disable is followed by a no-op.
        send(3'h7, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0130, 10'h000);
        send(3'h6, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h013F, 10'h000);
        #1;
        chk(irq_block, 1'b1, "block after enable");
        chk(rsp.sr, 16'h0138, "enable sr");
        send(3'h0, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0137, 10'h000);
        #1;
        chk(irq_block, 1'b0, "block after next");
        chk(rsp.sr, 16'h0137, "disable sr");
        take();
        // A stalled clock enable must keep the protection for the following instruction.
        send(3'h7, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 10'h000);
        send(3'h1, 1'b0, 1'b0, 1'b1, 16'h0005, 16'h0008, 10'h000);
        clock_en <= 1'b0;
        repeat (3) begin
            @(posedge clock);
            #1;
            chk(irq_block, 1'b1, "block held");
        end
        @(posedge clock);
        clock_en <= 1'b1;
        take();
        chk(irq_block, 1'b0, "block released");
        chk(rsp.result, 16'h0004, "dec after enable");
        finish_test();
    end

    // Watchdog: the tests need under 1000 cycles.
    initial begin
        repeat (4000) @(posedge clock);
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
